/* acrm_pkg.sv */
package acrm_pkg;
    typedef enum logic [1:0] {
        ACRM_IDLE = 2'h0,
        ACRM_RUN  = 2'h1,
        ACRM_DONE = 2'h3
    } acrm_fsm_t;

    typedef enum logic [1:0] {
        ACRM_CH_SHUNT = 2'h0,
        ACRM_CH_XFMR  = 2'h1,
        ACRM_CH_VOLT  = 2'h2
    } acrm_chan_t;

    typedef enum logic [1:0] {
        ACRM_MODE_NORMAL = 2'h0,
        ACRM_MODE_TURBO  = 2'h1,
        ACRM_MODE_LOW    = 2'h2
    } acrm_mode_t;

    typedef struct packed {
        acrm_fsm_t        fsm;
        logic [1:0]       ch;
        logic [1:0]       mode;
        logic             run_en;
        logic [31:0]      pre;
        logic [15:0]      sec;
        logic [15:0]      run_len;
        logic [15:0]      en_sec;
        logic             seen;
        logic             shifted;
        logic             done;
        logic [3:0]       flags;
        logic [2:0][31:0] cc;
        logic [2:0][31:0] estimate_certainty;
    } acrm_state_t;
endpackage

/* acrm_regs.svh */
// Functional notes
// - One channel per run, software-started.
// - Run lasts a fixed per-channel time.
// - Certainty exposed per channel after run.
// - Certainty in ppm, smaller is better.
// - Constant in amperes or volts per code.
// - Turbo four times faster; low power slower.
// - Warning flags share one status register.
// - Invalid setting raises configuration error.
// - Undetected calibration signal raises absent flag.
// - Enabled beyond 600 s raises timeout.
// - Mid-run shift raises flag, certainty above 50000.
`ifndef ACRM_REGS_SVH
`define ACRM_REGS_SVH
// ------------------------------------------------------------
// Configuration word layout
// ------------------------------------------------------------
`define ACRM_CFG_EN_BIT      0
`define ACRM_CFG_CH_LSB      1
`define ACRM_CFG_MODE_LSB    3
`define ACRM_CFG_RESET       5'h00
// ------------------------------------------------------------
// Warning status bits
// ------------------------------------------------------------
`define ACRM_FLAG_CONFERR    0
`define ACRM_FLAG_ABSENT     1
`define ACRM_FLAG_TIMEOUT    2
`define ACRM_FLAG_SHIFT      3
`define ACRM_FLAGS_RESET     4'h0
// ------------------------------------------------------------
// Timing and limits
// ------------------------------------------------------------
`define ACRM_CLK_HZ          40000000
`define ACRM_TIMEOUT_SEC     600
`define ACRM_TURBO_SHIFT     2
`define ACRM_LOW_SHIFT       1
`define ACRM_ESTIMATE_CERTAINTY_LIMIT_PPM  32'h0000C350
`define ACRM_ESTIMATE_CERTAINTY_SHIFT_PPM  32'h0000C351
`endif

/* acrm_top.sv */
`timescale 1ns/1ps
`include "acrm_regs.svh"
module acrm_top #(
    parameter int unsigned SEC_CYCLES    = `ACRM_CLK_HZ,
    parameter int unsigned RUN_SEC_SHUNT = 64,
    parameter int unsigned RUN_SEC_XFMR  = 64,
    parameter int unsigned RUN_SEC_VOLT  = 64,
    parameter int unsigned ABSENT_SEC    = 8
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    input  wire logic [4:0]  calib_run_config,
    input  wire logic        calib_config_write,
    input  wire logic        calib_warning_clear,
    input  wire logic [3:0]  calib_warning_clear_mask,
    input  wire logic [31:0] est_conversion_constant,
    input  wire logic [31:0] est_certainty,
    input  wire logic        est_signal_seen,
    input  wire logic        est_constant_shift,
    output logic [3:0]       calib_warning_status,
    output logic             run_busy,
    output logic             run_done,
    output logic [31:0]      shunt_conversion_constant,
    output logic [31:0]      xfmr_conversion_constant,
    output logic [31:0]      volt_conversion_constant,
    output logic [31:0]      shunt_estimate_certainty,
    output logic [31:0]      xfmr_estimate_certainty,
    output logic [31:0]      volt_estimate_certainty
);
    localparam logic [31:0] SEC_M1  = 32'(SEC_CYCLES - 1);
    localparam logic [15:0] TMO_SEC = 16'(`ACRM_TIMEOUT_SEC);
    localparam logic [15:0] ABS_SEC = 16'(ABSENT_SEC);

    acrm_pkg::acrm_state_t st;
    acrm_pkg::acrm_state_t next_st;

    logic       cfg_en;
    logic [1:0] cfg_ch;
    logic [1:0] cfg_mode;
    logic       cfg_bad;
    logic       tick;
    logic [15:0] next_len;

    assign cfg_en   = calib_run_config[`ACRM_CFG_EN_BIT];
    assign cfg_ch   = calib_run_config[`ACRM_CFG_CH_LSB +: 2];
    assign cfg_mode = calib_run_config[`ACRM_CFG_MODE_LSB +: 2];
    assign tick     = clk_en && (st.pre == SEC_M1);

    // ------------------------------------------------------------
    // Setting check and run length
    // ------------------------------------------------------------
    always_comb begin
        // Only current channels have power modes
        cfg_bad = (cfg_ch == 2'h3) || (cfg_mode == 2'h3) ||
                  ((cfg_ch == acrm_pkg::ACRM_CH_VOLT) &&
                   (cfg_mode != acrm_pkg::ACRM_MODE_NORMAL));
        case (cfg_ch)
            acrm_pkg::ACRM_CH_SHUNT: next_len = 16'(RUN_SEC_SHUNT);
            acrm_pkg::ACRM_CH_XFMR:  next_len = 16'(RUN_SEC_XFMR);
            default:                 next_len = 16'(RUN_SEC_VOLT);
        endcase
        case (cfg_mode)
            acrm_pkg::ACRM_MODE_TURBO: next_len = next_len >> `ACRM_TURBO_SHIFT;
            acrm_pkg::ACRM_MODE_LOW:   next_len = next_len << `ACRM_LOW_SHIFT;
            default:                   next_len = next_len;
        endcase
        if (next_len == 16'h0000) begin
            next_len = 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        if (clk_en) begin
            next_st.pre = tick ? 32'h0 : st.pre + 32'h1;
            // Clear first so that a set in the same cycle wins
            if (calib_warning_clear) begin
                next_st.flags = st.flags & ~calib_warning_clear_mask;
            end
            if (st.run_en && tick && (st.en_sec <= TMO_SEC)) begin
                next_st.en_sec = st.en_sec + 16'h1;
                if (st.en_sec == TMO_SEC) begin
                    next_st.flags[`ACRM_FLAG_TIMEOUT] = 1'b1;
                end
            end
            case (st.fsm)
                acrm_pkg::ACRM_IDLE, acrm_pkg::ACRM_DONE: begin
                    if (calib_config_write && cfg_en) begin
                        if (cfg_bad) begin
                            next_st.flags[`ACRM_FLAG_CONFERR] = 1'b1;
                        end else begin
                            next_st.fsm     = acrm_pkg::ACRM_RUN;
                            next_st.ch      = cfg_ch;
                            next_st.mode    = cfg_mode;
                            next_st.run_len = next_len;
                            next_st.sec     = 16'h0;
                            next_st.en_sec  = 16'h0;
                            next_st.pre     = 32'h0;
                            next_st.run_en  = 1'b1;
                            next_st.seen    = 1'b0;
                            next_st.shifted = 1'b0;
                            next_st.done    = 1'b0;
                        end
                    end else if (calib_config_write) begin
                        // Disable write; timeout stops counting here
                        next_st.run_en = 1'b0;
                        next_st.fsm    = acrm_pkg::ACRM_IDLE;
                        next_st.done   = 1'b0;
                    end
                end
                acrm_pkg::ACRM_RUN: begin
                    if (est_signal_seen) begin
                        next_st.seen = 1'b1;
                    end
                    if (est_constant_shift) begin
                        next_st.shifted = 1'b1;
                        next_st.flags[`ACRM_FLAG_SHIFT] = 1'b1;
                    end
                    if (calib_config_write && !cfg_en) begin
                        next_st.fsm    = acrm_pkg::ACRM_IDLE;
                        next_st.run_en = 1'b0;
                    end else if (calib_config_write) begin
                        // A second run cannot overlap the first
                        next_st.flags[`ACRM_FLAG_CONFERR] = 1'b1;
                    end else if (tick) begin
                        next_st.sec = st.sec + 16'h1;
                        if (!next_st.seen && (st.sec + 16'h1 == ABS_SEC)) begin
                            next_st.flags[`ACRM_FLAG_ABSENT] = 1'b1;
                            next_st.fsm = acrm_pkg::ACRM_IDLE;
                        end else if (st.sec + 16'h1 == st.run_len) begin
                            next_st.fsm  = acrm_pkg::ACRM_DONE;
                            next_st.done = 1'b1;
                            // Units follow the channel: A/code or V/code
                            next_st.cc[st.ch] = est_conversion_constant;
                            if (next_st.shifted &&
                                (est_certainty <= `ACRM_ESTIMATE_CERTAINTY_LIMIT_PPM)) begin
                                next_st.estimate_certainty[st.ch] = `ACRM_ESTIMATE_CERTAINTY_SHIFT_PPM;
                            end else begin
                                next_st.estimate_certainty[st.ch] = est_certainty;
                            end
                        end
                    end
                end
                default: begin
                    next_st.fsm = acrm_pkg::ACRM_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st         <= '0;
            st.fsm     <= acrm_pkg::ACRM_IDLE;
            st.flags   <= `ACRM_FLAGS_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign calib_warning_status      = st.flags;
    assign run_busy                  = (st.fsm == acrm_pkg::ACRM_RUN);
    assign run_done                  = st.done;
    assign shunt_conversion_constant = st.cc[0];
    assign xfmr_conversion_constant  = st.cc[1];
    assign volt_conversion_constant  = st.cc[2];
    assign shunt_estimate_certainty  = st.estimate_certainty[0];
    assign xfmr_estimate_certainty   = st.estimate_certainty[1];
    assign volt_estimate_certainty   = st.estimate_certainty[2];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_bad_request;
        clk_en && calib_config_write && cfg_en && cfg_bad && !run_busy;
    endsequence

    sequence s_last_second;
        run_busy && tick && !calib_config_write && st.seen &&
        (st.sec + 16'h1 == st.run_len);
    endsequence

    property p_conferr;
        s_bad_request |=> calib_warning_status[`ACRM_FLAG_CONFERR] && !run_busy;
    endproperty
    a_conferr: assert property (p_conferr) else $error("config error not flagged");

    property p_one_channel;
        run_busy && $past(run_busy) |-> $stable(st.ch);
    endproperty
    a_one_channel: assert property (p_one_channel) else $error("channel moved mid-run");

    property p_run_end;
        s_last_second |=> run_done && !run_busy ##1 !run_busy;
    endproperty
    a_run_end: assert property (p_run_end) else $error("run did not finish");

    property p_turbo_len;
        $rose(run_busy) && (st.mode == acrm_pkg::ACRM_MODE_TURBO) &&
        (st.ch == acrm_pkg::ACRM_CH_SHUNT) |-> st.run_len == 16'(RUN_SEC_SHUNT >> 2);
    endproperty
    a_turbo_len: assert property (p_turbo_len) else $error("turbo length wrong");

    property p_timeout;
        st.run_en && tick && (st.en_sec == TMO_SEC) |=>
            calib_warning_status[`ACRM_FLAG_TIMEOUT];
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout not flagged");

    property p_absent;
        run_busy && tick && !calib_config_write && !st.seen && !est_signal_seen &&
        (st.sec + 16'h1 == ABS_SEC) |=> calib_warning_status[`ACRM_FLAG_ABSENT] && !run_busy;
    endproperty
    a_absent: assert property (p_absent) else $error("absent not flagged");

    property p_shift_estimate_certainty;
        s_last_second ##0 st.shifted && (st.ch == acrm_pkg::ACRM_CH_SHUNT) |=>
            shunt_estimate_certainty > `ACRM_ESTIMATE_CERTAINTY_LIMIT_PPM;
    endproperty
    a_shift_estimate_certainty: assert property (p_shift_estimate_certainty) else $error("shift certainty low");

    property p_shift_flag;
        clk_en && run_busy && est_constant_shift |=> calib_warning_status[`ACRM_FLAG_SHIFT];
    endproperty
    a_shift_flag: assert property (p_shift_flag) else $error("shift not flagged");

    property p_sticky;
        calib_warning_status[`ACRM_FLAG_ABSENT] &&
        !(clk_en && calib_warning_clear && calib_warning_clear_mask[`ACRM_FLAG_ABSENT])
        |=> calib_warning_status[`ACRM_FLAG_ABSENT] [*1];
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped uncleared");

    property p_estimate_certainty_hold;
        !run_busy && !$rose(run_busy) |=> $stable(volt_estimate_certainty);
    endproperty
    a_estimate_certainty_hold: assert property (p_estimate_certainty_hold) else $error("certainty changed idle");
endmodule

/* autocal_run_monitor_test.sv */
`timescale 1ns/1ps
module autocal_run_monitor_test;
    // Short second so the timeout and long runs fit in a few thousand cycles
    localparam int unsigned SEC  = 4;
    localparam int unsigned BASE = 8;

    logic        clk;
    logic        rst_n;
    logic        clk_en;
    logic [4:0]  cfg;
    logic        cfg_wr;
    logic        clr;
    logic [3:0]  clr_mask;
    logic [31:0] cc_in;
    logic [31:0] estimate_certainty_in;
    logic        seen_in;
    logic        shift_in;
    wire  [3:0]  status;
    wire         busy;
    wire         done;
    wire  [31:0] cc_s, cc_x, cc_v, ce_s, ce_x, ce_v;
    int          fail_count;
    int          n_compared;

    acrm_top #(.SEC_CYCLES(SEC), .RUN_SEC_SHUNT(BASE), .RUN_SEC_XFMR(BASE),
               .RUN_SEC_VOLT(BASE), .ABSENT_SEC(4)) i_acrm_top (
        .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .calib_run_config(cfg),
        .calib_config_write(cfg_wr), .calib_warning_clear(clr),
        .calib_warning_clear_mask(clr_mask), .est_conversion_constant(cc_in),
        .est_certainty(estimate_certainty_in), .est_signal_seen(seen_in),
        .est_constant_shift(shift_in), .calib_warning_status(status),
        .run_busy(busy), .run_done(done),
        .shunt_conversion_constant(cc_s), .xfmr_conversion_constant(cc_x),
        .volt_conversion_constant(cc_v), .shunt_estimate_certainty(ce_s),
        .xfmr_estimate_certainty(ce_x), .volt_estimate_certainty(ce_v));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic wr(input logic [4:0] w);
        @(negedge clk);
        cfg    = w;
        cfg_wr = 1'b1;
        @(negedge clk);
        cfg_wr = 1'b0;
    endtask

    task automatic clear(input logic [3:0] m);
        @(negedge clk);
        clr_mask = m;
        clr      = 1'b1;
        @(negedge clk);
        clr      = 1'b0;
    endtask

    // Counts busy cycles until done or abort; optional mid-run shift pulse
    task automatic run(input logic [4:0] w, input logic shift, output int n);
        int i;
        n = 0;
        wr(w);
        for (i = 0; i < 400 && !(done || status[1]); i++) begin
            if (busy)
                n++;
            shift_in = shift && (i == 5);
            @(negedge clk);
        end
        shift_in = 1'b0;
        if (i == 400) begin
            fail_count++;
            end_sim();
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_one(input logic [1:0] ch, input logic [1:0] md, input int exp);
        int n;
        cc_in   = 32'h1234_0000 + 32'(exp) + 32'(ch);
        estimate_certainty_in = 32'h0000_0100 + 32'(exp);
        run({md, ch, 1'b1}, 1'b0, n);
        chk(32'(n), 32'(exp));
        chk(32'(done), 32'h1);
        chk(ch == 2'h0 ? cc_s : ch == 2'h1 ? cc_x : cc_v, cc_in);
        chk(ch == 2'h0 ? ce_s : ch == 2'h1 ? ce_x : ce_v, estimate_certainty_in);
        wr(5'h00);
        chk(32'(done), 32'h0);
        chk(32'(status), 32'h0);
        $display("test run ch %0d mode %0d done", ch, md);
    endtask

    task automatic t_conferr;
        wr({2'h0, 2'h3, 1'b1});
        @(negedge clk);
        chk(32'(status), 32'h1);
        chk(32'(busy), 32'h0);
        wr(5'h00);
        chk(32'(status), 32'h1);
        clear(4'h1);
        chk(32'(status), 32'h0);
        wr({2'h1, 2'h2, 1'b1});
        @(negedge clk);
        chk(32'(status), 32'h1);
        wr(5'h00);
        clear(4'h1);
        wr(5'h01);
        repeat (3) @(negedge clk);
        wr(5'h03);
        @(negedge clk);
        chk(32'(status), 32'h1);
        chk(32'(busy), 32'h1);
        wr(5'h00);
        clear(4'hF);
        $display("test conferr done");
    endtask

    task automatic t_absent;
        int          n;
        logic [31:0] old;
        old     = cc_s;
        seen_in = 1'b0;
        cc_in   = 32'hDEAD_0001;
        run(5'h01, 1'b0, n);
        chk(32'(status), 32'h2);
        chk(32'(done), 32'h0);
        chk(cc_s, old);
        seen_in = 1'b1;
        wr(5'h00);
        chk(32'(status), 32'h2);
        clear(4'h2);
        chk(32'(status), 32'h0);
        $display("test absent done");
    endtask

    task automatic t_shift;
        int n;
        estimate_certainty_in = 32'h0000_0064;
        run(5'h01, 1'b1, n);
        chk(32'(status), 32'h8);
        chk(ce_s, 32'h0000_C351);
        wr(5'h00);
        clear(4'h1);
        chk(32'(status), 32'h8);
        clear(4'h8);
        chk(32'(status), 32'h0);
        $display("test shift done");
    endtask

    task automatic t_timeout;
        int n;
        wr(5'h01);
        for (n = 0; n < 3000 && !status[2]; n++)
            @(negedge clk);
        if (n == 3000) begin
            fail_count++;
            end_sim();
        end
        // Enable held past the run end keeps the seconds counting
        chk(32'(n >= 2400 && n <= 2408), 32'h1);
        wr(5'h00);
        clear(4'h4);
        chk(32'(status), 32'h0);
        $display("test timeout done");
    endtask

    // ------------------------------------------------------------
    // Clock, reset and main sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        fail_count = 0;
        n_compared = 0;
        rst_n      = 1'b0;
        clk_en     = 1'b1;
        cfg        = 5'h00;
        cfg_wr     = 1'b0;
        clr        = 1'b0;
        clr_mask   = 4'h0;
        cc_in      = 32'h0;
        estimate_certainty_in    = 32'h0;
        seen_in    = 1'b1;
        shift_in   = 1'b0;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        chk(32'(status), 32'h0);
        chk(cc_s | cc_x | cc_v | ce_s | ce_x | ce_v, 32'h0);
        t_one(2'h0, 2'h0, BASE * SEC);
        t_one(2'h1, 2'h1, BASE * SEC / 4);
        t_one(2'h0, 2'h1, BASE * SEC / 4);
        t_one(2'h0, 2'h2, BASE * SEC * 2);
        t_one(2'h2, 2'h0, BASE * SEC);
        $display("test runs done");
        t_conferr();
        t_absent();
        t_shift();
        t_timeout();
        end_sim();
    end
endmodule

/* dummy_end_marker_not_used.sv */
`timescale 1ns/1ps
